// ---- vic_pkg.sv ----
// constants, source map and vector table of the vectored interrupt controller
package vic_pkg;
	localparam int NSRC = 22;
	// ---------------------------------------------------------------
	// register offsets (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] OFF_PRI_EN = 8'h00;
	localparam logic [7:0] OFF_PRI_PRIO = 8'h04;
	localparam logic [7:0] OFF_EXT1_EN = 8'h08;
	localparam logic [7:0] OFF_EXT1_PRIO = 8'h0C;
	localparam logic [7:0] OFF_EXT2_EN = 8'h10;
	localparam logic [7:0] OFF_EXT2_PRIO = 8'h14;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h1C;
	localparam logic [7:0] OFF_PENDING = 8'h20;
	localparam logic [7:0] OFF_SW_CLEAR = 8'h24;
	localparam logic [7:0] OFF_ACTIVE = 8'h28;
	localparam logic [31:0] RST_REG = 32'h0000_0000;
	// ---------------------------------------------------------------
	// sources
	// ---------------------------------------------------------------
	localparam int SRC_EXT_A = 0;
	localparam int SRC_EXT_B = 2;
	localparam int SRC_CONV_DONE = 10;
	localparam logic [NSRC-1:0] SRC_RESERVED = 22'h04_2000; // slots 13 and 18
	localparam logic [NSRC-1:0] SRC_HW_CLEAR = 22'h00_000F; // orders 0..3 cleared on vectoring
	localparam logic [NSRC-1:0] SRC_READ_ONLY = 22'h02_D100; // flags software cannot clear here
	localparam logic [15:0] VEC_BASE = 16'h0003;
	localparam logic [15:0] VEC_STEP = 16'h0008;
	localparam logic [15:0] VEC_RESET = 16'h0000;
	// event bits of the interrupt status register
	localparam int EV_VECTOR = 0;
	localparam int EV_PREEMPT = 1;
	localparam int EV_WAKE = 2;
	localparam int NEV = 3;
endpackage

// ---- vic_arbiter.sv ----
// fixed-order pick of the lowest pending source at one priority level
module vic_arbiter (
	input wire logic [21:0] req_i,
	output logic hit_o,
	output logic [4:0] idx_o
);
	// lowest order wins, so scan downward and keep the last hit
	always_comb begin
		hit_o = 1'b0;
		idx_o = 5'h00;
		for (int i = 21; i >= 0; i--) begin
			if (req_i[i]) begin
				hit_o = 1'b1;
				idx_o = 5'(i);
			end
		end
	end
endmodule

// ---- vic_top.sv ----
// vectored interrupt controller with axi4-lite register access
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
module vic_top (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ext_irq_a_input_i,
	input wire logic ext_irq_b_input_i,
	input wire logic [21:0] periph_flag_i,
	input wire logic idle_i,
	input wire logic vec_ack_i,
	input wire logic reti_i,
	output logic vec_req_o,
	output logic [15:0] vec_addr_o,
	output logic [4:0] vec_src_o,
	output logic wake_o,
	output logic irq_o,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam int N = vic_pkg::NSRC;
	localparam int NEV = vic_pkg::NEV;
	// ---------------------------------------------------------------
	// external pin synchronisers
	// ---------------------------------------------------------------
	logic [2:0] sa_r, sa_nxt, sb_r, sb_nxt;
	logic fall_a, fall_b;
	// third stage only compared with second, first feeds only second
	always_comb begin
		sa_nxt = {sa_r[1:0], ext_irq_a_input_i};
		sb_nxt = {sb_r[1:0], ext_irq_b_input_i};
	end
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			sa_r <= 3'h7;
			sb_r <= 3'h7;
		end else begin
			sa_r <= sa_nxt;
			sb_r <= sb_nxt;
		end
	end
	// active-low edge triggered inputs
	assign fall_a = sa_r[2] & ~sa_r[1];
	assign fall_b = sb_r[2] & ~sb_r[1];

	// ---------------------------------------------------------------
	// registers and state
	// ---------------------------------------------------------------
	logic [N-1:0] en_r, en_nxt, prio_r, prio_nxt, pend_r, pend_nxt;
	logic [NEV-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
	logic [1:0] act_r, act_nxt; // bit0 low level running, bit1 high level running
	logic req_r, req_nxt, wake_r, wake_nxt, irq_r, irq_nxt;
	logic [4:0] src_r, src_nxt;
	logic [15:0] addr_r, addr_nxt;

	// ---------------------------------------------------------------
	// arbitration per level
	// ---------------------------------------------------------------
	logic [N-1:0] live, req_hi, req_lo;
	logic hit_hi, hit_lo;
	logic [4:0] idx_hi, idx_lo;
	assign live = pend_r & en_r & ~vic_pkg::SRC_RESERVED;
	assign req_hi = live & prio_r;
	assign req_lo = live & ~prio_r;
	vic_arbiter u_arb_hi (.req_i(req_hi), .hit_o(hit_hi), .idx_o(idx_hi));
	vic_arbiter u_arb_lo (.req_i(req_lo), .hit_o(hit_lo), .idx_o(idx_lo));

	logic take_hi, take_lo;
	logic [4:0] pick;
	assign take_hi = hit_hi & ~act_r[1];
	assign take_lo = hit_lo & ~act_r[1] & ~act_r[0];
	assign pick = take_hi ? idx_hi : idx_lo;

	// ---------------------------------------------------------------
	// axi4-lite slave
	// ---------------------------------------------------------------
	logic aw_rdy_r, aw_rdy_nxt, w_rdy_r, w_rdy_nxt, bv_r, bv_nxt, rv_r, rv_nxt, ar_rdy_r, ar_rdy_nxt;
	logic [7:0] awa_r, awa_nxt;
	logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
	logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
	logic do_wr, wr_ok, rd_ok;
	logic [31:0] rdv;
	assign do_wr = ~aw_rdy_r & ~w_rdy_r & ~bv_r; // ready low means that beat is held
	// each channel taken on its own valid-ready edge; response only after both
	always_comb begin
		aw_rdy_nxt = aw_rdy_r;
		w_rdy_nxt = w_rdy_r;
		awa_nxt = awa_r;
		wd_nxt = wd_r;
		bv_nxt = bv_r;
		br_nxt = br_r;
		if (s_axi_awvalid & aw_rdy_r) begin
			aw_rdy_nxt = 1'b0;
			awa_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid & w_rdy_r) begin
			w_rdy_nxt = 1'b0;
			wd_nxt = s_axi_wdata;
		end
		if (do_wr) begin
			bv_nxt = 1'b1;
			br_nxt = wr_ok ? 2'h0 : 2'h2;
		end
		if (bv_r & s_axi_bready) begin
			bv_nxt = 1'b0;
			aw_rdy_nxt = 1'b1;
			w_rdy_nxt = 1'b1;
		end
	end
	// read decode; unmapped offsets answer slverr
	always_comb begin
		rdv = 32'h0000_0000;
		rd_ok = 1'b1;
		unique case (s_axi_araddr)
			vic_pkg::OFF_PRI_EN: rdv[7:0] = en_r[7:0];
			vic_pkg::OFF_PRI_PRIO: rdv[7:0] = prio_r[7:0];
			vic_pkg::OFF_EXT1_EN: rdv[7:0] = en_r[15:8];
			vic_pkg::OFF_EXT1_PRIO: rdv[7:0] = prio_r[15:8];
			vic_pkg::OFF_EXT2_EN: rdv[5:0] = en_r[21:16];
			vic_pkg::OFF_EXT2_PRIO: rdv[5:0] = prio_r[21:16];
			vic_pkg::OFF_IRQ_STAT: rdv[NEV-1:0] = stat_r;
			vic_pkg::OFF_IRQ_MASK: rdv[NEV-1:0] = mask_r;
			vic_pkg::OFF_PENDING: rdv[N-1:0] = pend_r;
			vic_pkg::OFF_SW_CLEAR: rdv = 32'h0000_0000;
			vic_pkg::OFF_ACTIVE: rdv[1:0] = act_r;
			default: rd_ok = 1'b0;
		endcase
	end
	always_comb begin
		rv_nxt = rv_r;
		rd_nxt = rd_r;
		rr_nxt = rr_r;
		ar_rdy_nxt = ar_rdy_r;
		if (s_axi_arvalid & ar_rdy_r) begin
			rv_nxt = 1'b1;
			ar_rdy_nxt = 1'b0;
			rd_nxt = rdv;
			rr_nxt = rd_ok ? 2'h0 : 2'h2;
		end else if (rv_r & s_axi_rready) begin
			rv_nxt = 1'b0;
			ar_rdy_nxt = 1'b1;
		end
	end
	always_comb begin
		wr_ok = 1'b1;
		unique case (awa_r)
			vic_pkg::OFF_PRI_EN, vic_pkg::OFF_PRI_PRIO, vic_pkg::OFF_EXT1_EN, vic_pkg::OFF_EXT1_PRIO,
			vic_pkg::OFF_EXT2_EN, vic_pkg::OFF_EXT2_PRIO, vic_pkg::OFF_IRQ_STAT, vic_pkg::OFF_IRQ_MASK,
			vic_pkg::OFF_SW_CLEAR: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	// ---------------------------------------------------------------
	// controller next state
	// ---------------------------------------------------------------
	logic [N-1:0] clr_sw;
	logic vec_fire;
	logic [NEV-1:0] ev;
	assign vec_fire = req_r & vec_ack_i;
	always_comb begin
		en_nxt = en_r;
		prio_nxt = prio_r;
		mask_nxt = mask_r;
		clr_sw = '0;
		if (do_wr & s_axi_wstrb[0]) begin
			unique case (awa_r)
				vic_pkg::OFF_PRI_EN: en_nxt[7:0] = wd_r[7:0];
				vic_pkg::OFF_PRI_PRIO: prio_nxt[7:0] = wd_r[7:0];
				vic_pkg::OFF_EXT1_EN: en_nxt[15:8] = wd_r[7:0];
				vic_pkg::OFF_EXT1_PRIO: prio_nxt[15:8] = wd_r[7:0];
				vic_pkg::OFF_EXT2_EN: en_nxt[21:16] = wd_r[5:0];
				vic_pkg::OFF_EXT2_PRIO: prio_nxt[21:16] = wd_r[5:0];
				vic_pkg::OFF_IRQ_MASK: mask_nxt = wd_r[NEV-1:0];
				default: ;
			endcase
		end
		if (do_wr && awa_r == vic_pkg::OFF_SW_CLEAR && (&s_axi_wstrb[2:0]))
			clr_sw = wd_r[N-1:0] & ~vic_pkg::SRC_READ_ONLY; // read-only untouched
	end
	always_comb begin
		pend_nxt = pend_r & ~clr_sw;
		if (vec_fire && vic_pkg::SRC_HW_CLEAR[src_r])
			pend_nxt[src_r] = 1'b0;
		// sources set after clears so a coincident event wins
		pend_nxt = pend_nxt | (periph_flag_i & ~vic_pkg::SRC_RESERVED & ~vic_pkg::SRC_HW_CLEAR);
		pend_nxt[1] = pend_nxt[1] | periph_flag_i[1];
		pend_nxt[3] = pend_nxt[3] | periph_flag_i[3];
		pend_nxt[vic_pkg::SRC_EXT_A] = pend_nxt[vic_pkg::SRC_EXT_A] | fall_a;
		pend_nxt[vic_pkg::SRC_EXT_B] = pend_nxt[vic_pkg::SRC_EXT_B] | fall_b;
	end
	always_comb begin
		req_nxt = req_r;
		src_nxt = src_r;
		addr_nxt = addr_r;
		act_nxt = act_r;
		wake_nxt = 1'b0;
		ev = '0;
		if (reti_i) begin
			if (act_r[1])
				act_nxt[1] = 1'b0;
			else
				act_nxt[0] = 1'b0;
		end
		if (vec_fire) begin
			req_nxt = 1'b0;
			act_nxt[prio_r[src_r]] = 1'b1;
			ev[vic_pkg::EV_VECTOR] = 1'b1;
			ev[vic_pkg::EV_PREEMPT] = prio_r[src_r] & act_r[0];
		end else if (!req_r && (take_hi || take_lo) && !reti_i) begin
			req_nxt = 1'b1;
			src_nxt = pick;
			addr_nxt = vic_pkg::VEC_BASE + 16'({11'h000, pick} * vic_pkg::VEC_STEP);
			wake_nxt = idle_i;
			ev[vic_pkg::EV_WAKE] = idle_i;
		end
	end
	// events set sticky bits; set beats write-one clear
	always_comb begin
		stat_nxt = stat_r;
		if (do_wr && awa_r == vic_pkg::OFF_IRQ_STAT && s_axi_wstrb[0])
			stat_nxt = stat_r & ~wd_r[NEV-1:0];
		stat_nxt = stat_nxt | ev;
		irq_nxt = |(stat_nxt & mask_nxt);
	end
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			en_r <= '0;
			prio_r <= '0;
			pend_r <= '0;
			mask_r <= '0;
			stat_r <= '0;
			act_r <= 2'h0;
			req_r <= 1'b0;
			src_r <= 5'h00;
			addr_r <= vic_pkg::VEC_RESET;
			wake_r <= 1'b0;
			irq_r <= 1'b0;
			aw_rdy_r <= 1'b1;
			w_rdy_r <= 1'b1;
			awa_r <= 8'h00;
			wd_r <= vic_pkg::RST_REG;
			bv_r <= 1'b0;
			br_r <= 2'h0;
			rv_r <= 1'b0;
			rd_r <= vic_pkg::RST_REG;
			rr_r <= 2'h0;
			ar_rdy_r <= 1'b1;
		end else begin
			en_r <= en_nxt;
			prio_r <= prio_nxt;
			pend_r <= pend_nxt;
			mask_r <= mask_nxt;
			stat_r <= stat_nxt;
			act_r <= act_nxt;
			req_r <= req_nxt;
			src_r <= src_nxt;
			addr_r <= addr_nxt;
			wake_r <= wake_nxt;
			irq_r <= irq_nxt;
			aw_rdy_r <= aw_rdy_nxt;
			w_rdy_r <= w_rdy_nxt;
			awa_r <= awa_nxt;
			wd_r <= wd_nxt;
			bv_r <= bv_nxt;
			br_r <= br_nxt;
			rv_r <= rv_nxt;
			rd_r <= rd_nxt;
			rr_r <= rr_nxt;
			ar_rdy_r <= ar_rdy_nxt;
		end
	end

	// outputs straight from flip-flops
	assign vec_req_o = req_r;
	assign vec_addr_o = addr_r;
	assign vec_src_o = src_r;
	assign wake_o = wake_r;
	assign irq_o = irq_r;
	assign s_axi_awready = aw_rdy_r;
	assign s_axi_wready = w_rdy_r;
	assign s_axi_bvalid = bv_r;
	assign s_axi_bresp = br_r;
	assign s_axi_arready = ar_rdy_r;
	assign s_axi_rvalid = rv_r;
	assign s_axi_rdata = rd_r;
	assign s_axi_rresp = rr_r;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	a_ext_a_vector:
	assert property (@(posedge clk_sys_i) disable iff (rst_i)
		req_r && src_r == 5'd0 |-> addr_r == 16'h0003) else $error("ext a vector wrong");
	a_ext_b_vector:
	assert property (@(posedge clk_sys_i) disable iff (rst_i)
		req_r && src_r == 5'd2 |-> addr_r == 16'h0013) else $error("ext b vector wrong");
	a_conv_keep:
	assert property (@(posedge clk_sys_i) disable iff (rst_i)
		vec_fire && src_r == 5'd10 && !clr_sw[10] |=> pend_r[10]) else $error("conv flag cleared by hw");
	a_ro_flag_kept:
	assert property (@(posedge clk_sys_i) disable iff (rst_i)
		pend_r[8] && !(vec_fire && src_r == 5'd8) |=> pend_r[8]) else $error("read-only flag cleared");
	a_vec_spacing:
	assert property (@(posedge clk_sys_i) disable iff (rst_i)
		$rose(req_r) |-> addr_r == 16'h0003 + 16'({11'h000, src_r} * 16'h0008)) else $error("vector spacing");
	a_reserved_none:
	assert property (@(posedge clk_sys_i) disable iff (rst_i)
		req_r |-> src_r != 5'd13 && src_r != 5'd18) else $error("reserved slot vectored");
	a_enable_gate:
	assert property (@(posedge clk_sys_i) disable iff (rst_i)
		$rose(req_r) |-> $past(en_r[pick])) else $error("disabled source vectored");
	a_wake_vector:
	assert property (@(posedge clk_sys_i) disable iff (rst_i)
		wake_r |-> req_r && $past(idle_i)) else $error("wake without vector");
	a_no_preempt_eq:
	assert property (@(posedge clk_sys_i) disable iff (rst_i)
		$rose(req_r) && $past(act_r[1]) |-> 1'b0) else $error("preempted high level");
endmodule

// ---- cpu_core_model.sv ----
// core-side model: takes each offered vector after a chosen delay
module cpu_core_model (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic vec_req_i,
	input wire logic [3:0] ack_dly_i,
	output logic vec_ack_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] wait_r;
	logic [3:0] wait_nxt;
	logic ack_nxt;
	// count how long the offer stands; a slow core lets it wait
	always_comb begin
		wait_nxt = (vec_req_i && !vec_ack_o) ? wait_r + 4'h1 : 4'h0;
		ack_nxt = vec_req_i && !vec_ack_o && (wait_r >= ack_dly_i);
	end
	// one-cycle ack, never twice for the same offer
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			wait_r <= 4'h0;
			vec_ack_o <= 1'b0;
		end else begin
			wait_r <= wait_nxt;
			vec_ack_o <= ack_nxt;
		end
	end
endmodule

// ---- vectored_interrupt_controller_bench.sv ----
// self-checking bench of the vectored interrupt controller
module vectored_interrupt_controller_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_i, rst_i, ext_irq_a_input_i, ext_irq_b_input_i, idle_i, vec_ack_i, reti_i;
	logic vec_req_o, wake_o, irq_o, woke;
	logic [21:0] periph_flag_i, pat;
	logic [15:0] vec_addr_o;
	logic [4:0] vec_src_o;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed;
	logic [3:0] s_axi_wstrb, dly;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [33:0] rq[$], bq[$];
	logic [15:0] vq[$];
	int mismatches, compares;
	vic_top u_dut (.clk_sys_i, .rst_i, .ext_irq_a_input_i, .ext_irq_b_input_i, .periph_flag_i, .idle_i,
		.vec_ack_i, .reti_i, .vec_req_o, .vec_addr_o, .vec_src_o, .wake_o, .irq_o, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	cpu_core_model u_cpu (.clk_sys_i, .rst_i, .vec_req_i(vec_req_o), .ack_dly_i(dly), .vec_ack_o(vec_ack_i));
	// 25 MHz system clock
	initial begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h wanted %h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	// axi write; each channel released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] be = 2'h0);
		bq.push_back(34'(be));
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) s_axi_bready <= 1'b0;
		end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
	endtask
	// axi read; the watcher compares the answer
	task automatic rd(input logic [7:0] a, input logic [33:0] exp);
		rq.push_back(exp);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) s_axi_rready <= 1'b0;
		end while (s_axi_arvalid || s_axi_rready);
	endtask
	task automatic ret();
		reti_i <= 1'b1;
		tick(1);
		reti_i <= 1'b0;
	endtask
	// take one vector, clear by software if asked, then maybe return
	task automatic serve(input logic [15:0] exp, input logic [21:0] clr, input logic back);
		int n;
		n = 0;
		vq.push_back(exp);
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (!(vec_req_o && vec_ack_i) && n < 300);
		if (n >= 300) chk(34'h0, 34'h1);
		if (clr !== 22'h0) wr(vic_pkg::OFF_SW_CLEAR, 32'(clr));
		if (back) ret();
	endtask
	task automatic pulse(input logic [21:0] p);
		periph_flag_i <= p;
		tick(1);
		periph_flag_i <= 22'h0;
	endtask
	task automatic close_out();
		if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// watcher: results against the oldest note
	always @(posedge clk_sys_i) begin
		if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
		if (s_axi_bvalid && s_axi_bready) chk(34'(s_axi_bresp), bq.pop_front());
		if (vec_req_o && vec_ack_i) chk(34'(vec_src_o), 34'((vq[0] - 16'h0003) >> 3));
		if (vec_req_o && vec_ack_i) chk(34'(vec_addr_o), 34'(vq.pop_front()));
		if (wake_o) woke <= 1'b1;
	end
	// watchdog, far beyond the expected run
	initial begin
		#2000000;
		mismatches++;
		close_out();
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{ext_irq_a_input_i, ext_irq_b_input_i, rst_i, s_axi_wstrb} = 7'h7F;
		{idle_i, reti_i, periph_flag_i, dly, woke, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		mismatches = 0;
		compares = 0;
		seed = 32'hBECA553B;
		tick(5);
		rst_i <= 1'b0;
		tick(1);
		rd(vic_pkg::OFF_PRI_EN, 34'h0);
		rd(8'hFC, {2'h2, 32'h0});
		wr(8'hFC, 32'h0, 2'h2);
		wr(vic_pkg::OFF_PRI_EN, 32'hFF);
		wr(vic_pkg::OFF_EXT1_EN, 32'hFF);
		wr(vic_pkg::OFF_EXT2_EN, 32'h3F);
		rd(vic_pkg::OFF_EXT2_EN, 34'h3F);
		wr(vic_pkg::OFF_IRQ_MASK, 32'h7);
		// pin a while idle: wakes and vectors straight to it
		idle_i <= 1'b1;
		ext_irq_a_input_i <= 1'b0;
		serve(16'h0003, 22'h0, 1'b1);
		ext_irq_a_input_i <= 1'b1;
		idle_i <= 1'b0;
		chk(34'(woke), 34'h1);
		rd(vic_pkg::OFF_PENDING, 34'h0);
		rd(vic_pkg::OFF_IRQ_STAT, 34'h5);
		chk(34'(irq_o), 34'h1);
		wr(vic_pkg::OFF_IRQ_MASK, 32'h0);
		tick(2);
		chk(34'(irq_o), 34'h0);
		wr(vic_pkg::OFF_IRQ_MASK, 32'h7);
		tick(2);
		chk(34'(irq_o), 34'h1);
		wr(vic_pkg::OFF_IRQ_STAT, 32'h7);
		tick(2);
		chk(34'(irq_o), 34'h0);
		// pin b with a slow core
		dly <= 4'h6;
		ext_irq_b_input_i <= 1'b0;
		serve(16'h0013, 22'h0, 1'b1);
		ext_irq_b_input_i <= 1'b1;
		rd(vic_pkg::OFF_PENDING, 34'h0);
		// conversion done stays pending until software clears it
		pulse(22'h400);
		serve(16'h0053, 22'h0, 1'b0);
		rd(vic_pkg::OFF_PENDING, 34'h400);
		wr(vic_pkg::OFF_SW_CLEAR, 32'h400);
		rd(vic_pkg::OFF_PENDING, 34'h0);
		ret();
		// read-only flag: clear refused, only the enable holds it off
		wr(vic_pkg::OFF_EXT1_EN, 32'hFE);
		pulse(22'h100);
		tick(20);
		chk(34'(vec_req_o), 34'h0);
		wr(vic_pkg::OFF_SW_CLEAR, 32'h100);
		rd(vic_pkg::OFF_PENDING, 34'h100);
		// high level preempts a low routine, low waits for both returns
		wr(vic_pkg::OFF_PRI_PRIO, 32'h04);
		wr(vic_pkg::OFF_IRQ_STAT, 32'h7);
		pulse(22'h10);
		serve(16'h0023, 22'h0, 1'b0);
		ext_irq_b_input_i <= 1'b0;
		pulse(22'h20);
		serve(16'h0013, 22'h0, 1'b0);
		ret();
		tick(10);
		chk(34'(vec_req_o), 34'h0);
		wr(vic_pkg::OFF_SW_CLEAR, 32'h10);
		ext_irq_b_input_i <= 1'b1;
		ret();
		serve(16'h002B, 22'h20, 1'b1);
		rd(vic_pkg::OFF_IRQ_STAT, 34'h3);
		wr(vic_pkg::OFF_PRI_PRIO, 32'h0);
		// random ties at one level, reserved slots always offered
		repeat (4) begin
			seed = xs(seed);
			dly <= seed[25:22];
			pat = (seed[21:0] & ~22'h02_D105) | 22'h04_2000;
			pulse(pat);
			for (int i = 0; i < 22; i++) begin
				if (pat[i] && i != 13 && i != 18) serve(16'h0003 + 16'(8 * i), 22'(1 << i), 1'b1);
			end
			tick(10);
			chk(34'(vec_req_o), 34'h0);
		end
		close_out();
	end
endmodule
